/* File: design/adaptive_step_pkg.sv */
// constants shared by the load adaptive step and diagnostic output logic
package adaptive_step_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_RUN = 2'b01,
      ST_WAIT = 2'b10
   } seq_state_e;

   // diagnostic source select codes
   localparam logic [1:0] DIAG_SRC_STALL = 2'h0;
   localparam logic [1:0] DIAG_SRC_INDEX = 2'h1;
   localparam logic [1:0] DIAG_SRC_CHOP_ON = 2'h2;
   localparam logic [1:0] DIAG_SRC_SKIPPED = 2'h3;

   // table positions in one fullstep; also the step buffer limit
   localparam logic [9:0] FULLSTEP_POS = 10'h100;
   // step input high length that overrides a wait, in system clocks
   localparam logic [10:0] LONG_STEP_CYC = 11'h401;
   // off time settings above this behave as this value in adaptive mode
   localparam logic [3:0] OFF_TIME_CAP = 4'h8;
   // load measurement saturation value
   localparam logic [15:0] LOAD_SAT = 16'h01FF;
   // stall limit grows by this shift per step of lower sensitivity
   localparam int STALL_SHIFT = 2;
   // widths of the counters
   localparam int WAIT_CNT_W = 16;
   localparam int LOST_W = 20;

   // values after reset
   localparam logic [9:0] MSCNT_RST = 10'h000;
   localparam logic [LOST_W-1:0] LOST_RST = 20'h00000;
   localparam logic [8:0] LOAD_RST = 9'h000;
   localparam logic [3:0] OFF_TIME_RST = 4'h0;

endpackage

/* File: design/pin_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // asynchronous pins and their synchronised copies
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            meta_q[i] <= 1'b0;
            sync_out[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_in[i];
            sync_out[i] <= meta_q[i];
         end
      end
   end

endmodule // pin_sync

/* File: design/diag_out_drive.sv */
// one diagnostic pin: source select and output type
module diag_out_drive #(
   parameter bit LOW_IN_RESET = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // configuration: source and push-pull type
   input wire logic [1:0] src_sel,
   input wire logic push_pull,
   // candidate source levels, active high
   input wire logic src_stall,
   input wire logic src_index,
   input wire logic src_chop_on,
   input wire logic src_skipped,
   // pin output and enable
   output logic pin_o,
   output logic pin_oe
);

   logic level;

   // source select
   always_comb begin
      if (src_sel == adaptive_step_pkg::DIAG_SRC_STALL) begin
         level = src_stall;
      end else if (src_sel == adaptive_step_pkg::DIAG_SRC_INDEX) begin
         level = src_index;
      end else if (src_sel == adaptive_step_pkg::DIAG_SRC_CHOP_ON) begin
         level = src_chop_on;
      end else begin
         level = src_skipped;
      end
   end

   // open drain low or push-pull high
   // first pin pulls low in reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_o <= 1'b0;
         pin_oe <= LOW_IN_RESET;
      end else if (push_pull) begin
         pin_o <= level;
         pin_oe <= 1'b1;
      end else begin
         pin_o <= 1'b0;
         pin_oe <= level; // drive low only when asserted
      end
   end

   property p_od_type;
      @(posedge clk) disable iff (!resetn)
      (!push_pull && level) |=> (pin_oe && !pin_o);
   endproperty
   a_od_type: assert property (p_od_type) else $error("open drain not pulled low");

endmodule // diag_out_drive

/* File: design/load_adaptive_step_diag.sv */
// load adaptive step sequencer with diagnostic outputs
//
// Function
// - each diag pin has selectable source and open drain or push-pull type.
// - first diag pin is pulled low during power-on reset.
// - stall source shows detected motor stall like a stop switch.
// - index source is asserted while microstep counter is zero.
// - index lasts one microstep, possibly only one clock when buffered steps run back to back.
// - chopper on source shows on phase of both coils, alternating.
// - skipped source toggles for every commanded step not executed.
// - adaptive mode slows under overload, sets stall flag when blocked.
// - load measurement value readable in adaptive mode, range up to 511.
// - both high velocity flags force fullstep above the lower threshold.
// - off time settings 8 to 15 act as 8 in adaptive mode.
// - zero threshold disables; blocked motor still moves at threshold velocity.
// - adaptive mode disabled while the quiet chopper is active.
// - pulse width setting is the load measurement reference in clocks.
// - stall sensitivity setting governs stall detection, higher is more sensitive.
// - readable counter of commanded but unexecuted steps.
// - adaptive mode forces constant off time with slow decay.
// - force input high selects adaptive stepping.
// - ready low while motor cannot step; controller holds off steps.
// - waiting sequencer buffers steps up to one fullstep worth.
// - step held high over 1024 clocks executes regardless of ready.
// - sync input suspends execution and disables ready.
// - sync input acts when low, forcing ready low.
// - lost counter counts up or down by direction per skipped step.
module load_adaptive_step_diag (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // step interface pins from the motion controller
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic adaptive_force_in,
   input wire logic step_wait_sync_in,
   output logic step_ready_out,
   // velocity and mode configuration
   input wire logic [22:0] adaptive_min_velocity,
   input wire logic [22:0] velocity_in,
   input wire logic quiet_chopper_active,
   input wire logic vhigh_fullstep_en,
   input wire logic vhigh_chopper_en,
   input wire logic [3:0] chopper_off_time,
   input wire logic [8:0] microstep_width,
   input wire logic [15:0] blocked_step_period,
   // load measurement configuration and motor feedback
   input wire logic [9:0] load_meas_pulse_width,
   input wire logic [7:0] adaptive_stall_sensitivity,
   input wire logic motor_step_done,
   input wire logic chop_on_a,
   input wire logic chop_on_b,
   // diagnostic pin configuration
   input wire logic [1:0] diag_first_src,
   input wire logic diag_first_push_pull,
   input wire logic [1:0] diag_second_src,
   input wire logic diag_second_push_pull,
   // diagnostic pins
   output logic diag_out_first_o,
   output logic diag_out_first_oe,
   output logic diag_out_second_o,
   output logic diag_out_second_oe,
   // status and chopper control
   output logic [9:0] mscnt_out,
   output logic [adaptive_step_pkg::LOST_W-1:0] lost_steps_out,
   output logic [8:0] load_value_out,
   output logic stall_flag_out,
   output logic adaptive_active_out,
   output logic fullstep_mode_out,
   output logic const_off_slow_decay_out,
   output logic [3:0] eff_off_time_out
);

   logic [3:0] pins_s;
   logic step_s;
   logic dir_s;
   logic force_s;
   logic sync_s;
   adaptive_step_pkg::seq_state_e st_q;
   logic step_prev_q;
   logic [10:0] step_high_q;
   logic [9:0] pend_q;
   logic [9:0] fs_acc_q;
   logic [adaptive_step_pkg::WAIT_CNT_W-1:0] wait_cnt_q;
   logic skip_q;
   logic chop_sel_q;
   logic chop_prev_q;
   logic chop_on_q;
   logic index_q;
   logic active_d;
   logic above_min;
   logic step_ev;
   logic override_ev;
   logic can_exec;
   logic [9:0] width10;
   logic [9:0] exec_amt;
   logic [9:0] avail;
   logic accept;
   logic lost_ev;
   logic fs_done;
   logic [15:0] stall_limit;
   logic stall_ev;
   logic chop_shown;

   // pins pass two flops before any logic reads them
   pin_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({step_in, dir_in, adaptive_force_in, step_wait_sync_in}),
      .sync_out(pins_s)
   );
   assign {step_s, dir_s, force_s, sync_s} = pins_s;

   // mode decision from velocity and force pin
   assign above_min = (adaptive_min_velocity != 23'h000000) && (velocity_in > adaptive_min_velocity);
   assign active_d = !quiet_chopper_active && (force_s || above_min);

   // step edge and long step override detection
   assign step_ev = step_s && !step_prev_q;
   assign override_ev = step_s && (step_high_q == adaptive_step_pkg::LONG_STEP_CYC);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         step_prev_q <= 1'b0;
         step_high_q <= 11'h000;
      end else begin
         step_prev_q <= step_s;
         if (!step_s) begin
            step_high_q <= 11'h000;
         end else if (step_high_q <= adaptive_step_pkg::LONG_STEP_CYC) begin
            step_high_q <= step_high_q + 11'h001; // stops past the limit: one override
         end
      end
   end

   // step buffer arithmetic, in table positions
   assign width10 = {1'b0, microstep_width};
   assign can_exec = sync_s && (st_q != adaptive_step_pkg::ST_WAIT);
   assign exec_amt = !can_exec ? 10'h000 : ((pend_q >= width10) ? width10 : pend_q);
   assign avail = pend_q - exec_amt;
   assign accept = step_ev && ((avail + width10) <= adaptive_step_pkg::FULLSTEP_POS);
   assign lost_ev = step_ev && !accept;
   assign fs_done = (st_q == adaptive_step_pkg::ST_RUN) && (exec_amt != 10'h000) &&
      ((fs_acc_q + exec_amt) >= adaptive_step_pkg::FULLSTEP_POS);

   // pending positions and microstep counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 10'h000;
         mscnt_out <= adaptive_step_pkg::MSCNT_RST;
      end else begin
         pend_q <= accept ? (avail + width10) : avail;
         if (dir_s) begin
            mscnt_out <= mscnt_out - exec_amt;
         end else begin
            mscnt_out <= mscnt_out + exec_amt;
         end
      end
   end

   // position within the current fullstep
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fs_acc_q <= 10'h000;
      end else if (st_q != adaptive_step_pkg::ST_RUN || fs_done) begin
         fs_acc_q <= 10'h000;
      end else begin
         fs_acc_q <= fs_acc_q + exec_amt;
      end
   end

   // sequencer: wait for the motor after each executed fullstep
   // slow down instead of stalling
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= adaptive_step_pkg::ST_NORMAL;
      end else if (!active_d) begin
         st_q <= adaptive_step_pkg::ST_NORMAL;
      end else begin
         case (st_q)
            adaptive_step_pkg::ST_NORMAL: begin
               st_q <= adaptive_step_pkg::ST_RUN;
            end
            adaptive_step_pkg::ST_RUN: begin
               if (fs_done) begin
                  st_q <= adaptive_step_pkg::ST_WAIT;
               end
            end
            adaptive_step_pkg::ST_WAIT: begin
               if (motor_step_done || override_ev || (wait_cnt_q >= blocked_step_period)) begin
                  st_q <= adaptive_step_pkg::ST_RUN;
               end
            end
            default: begin
               st_q <= adaptive_step_pkg::ST_NORMAL;
            end
         endcase
      end
   end

   // wait counter doubles as the load measurement
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_cnt_q <= '0;
      end else if (st_q != adaptive_step_pkg::ST_WAIT) begin
         wait_cnt_q <= '0;
      end else if (wait_cnt_q != '1) begin
         wait_cnt_q <= wait_cnt_q + 16'h0001;
      end
   end

   // reference pulse width sets the base
   assign stall_limit = {6'h00, load_meas_pulse_width} +
      {6'h00, ~adaptive_stall_sensitivity, 2'h0};
   assign stall_ev = (st_q == adaptive_step_pkg::ST_WAIT) && (wait_cnt_q == stall_limit);

   // load value captured per motor step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         load_value_out <= adaptive_step_pkg::LOAD_RST;
      end else if ((st_q == adaptive_step_pkg::ST_WAIT) && motor_step_done) begin
         if (wait_cnt_q > adaptive_step_pkg::LOAD_SAT) begin
            load_value_out <= adaptive_step_pkg::LOAD_SAT[8:0];
         end else begin
            load_value_out <= wait_cnt_q[8:0];
         end
      end
   end

   // stall flag, set wins over the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stall_flag_out <= 1'b0;
      end else if (stall_ev) begin
         stall_flag_out <= 1'b1;
      end else if (motor_step_done || !active_d) begin
         stall_flag_out <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lost_steps_out <= adaptive_step_pkg::LOST_RST;
         skip_q <= 1'b0;
      end else if (lost_ev) begin
         skip_q <= !skip_q;
         if (dir_s) begin
            lost_steps_out <= lost_steps_out - 20'h00001;
         end else begin
            lost_steps_out <= lost_steps_out + 20'h00001;
         end
      end
   end

   // ready low while waiting for the motor
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         step_ready_out <= 1'b0;
      end else begin
         step_ready_out <= sync_s && (st_q != adaptive_step_pkg::ST_WAIT);
      end
   end

   // chopper control outputs
   // constant off time, slow decay
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         adaptive_active_out <= 1'b0;
         const_off_slow_decay_out <= 1'b0;
         fullstep_mode_out <= 1'b0;
         eff_off_time_out <= adaptive_step_pkg::OFF_TIME_RST;
      end else begin
         adaptive_active_out <= active_d;
         const_off_slow_decay_out <= active_d;
         fullstep_mode_out <= active_d && vhigh_fullstep_en && vhigh_chopper_en && above_min;
         if (active_d && (chopper_off_time > adaptive_step_pkg::OFF_TIME_CAP)) begin
            eff_off_time_out <= adaptive_step_pkg::OFF_TIME_CAP;
         end else begin
            eff_off_time_out <= chopper_off_time;
         end
      end
   end

   // alternate coils at the end of each on phase
   // quiet chopper has no on phase to show, so the source stays low
   assign chop_shown = chop_sel_q ? chop_on_b : chop_on_a;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chop_sel_q <= 1'b0;
         chop_prev_q <= 1'b0;
         chop_on_q <= 1'b0;
      end else begin
         chop_prev_q <= chop_shown;
         chop_on_q <= chop_shown && !quiet_chopper_active;
         if (chop_prev_q && !chop_shown) begin
            chop_sel_q <= !chop_sel_q;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         index_q <= 1'b0;
      end else begin
         index_q <= (mscnt_out == 10'h000);
      end
   end

   // both pins with own source and type
   diag_out_drive #(
      .LOW_IN_RESET(1'b1)
   ) u_diag_first (
      .clk(clk),
      .resetn(resetn),
      .src_sel(diag_first_src),
      .push_pull(diag_first_push_pull),
      .src_stall(stall_flag_out),
      .src_index(index_q),
      .src_chop_on(chop_on_q),
      .src_skipped(skip_q),
      .pin_o(diag_out_first_o),
      .pin_oe(diag_out_first_oe)
   );

   diag_out_drive #(
      .LOW_IN_RESET(1'b0)
   ) u_diag_second (
      .clk(clk),
      .resetn(resetn),
      .src_sel(diag_second_src),
      .push_pull(diag_second_push_pull),
      .src_stall(stall_flag_out),
      .src_index(index_q),
      .src_chop_on(chop_on_q),
      .src_skipped(skip_q),
      .pin_o(diag_out_second_o),
      .pin_oe(diag_out_second_oe)
   );

   // checks on the sequencer and its outputs
   property p_wait_ready;
      @(posedge clk) disable iff (!resetn)
      (st_q == adaptive_step_pkg::ST_WAIT) |=> !step_ready_out;
   endproperty
   a_wait_ready: assert property (p_wait_ready) else $error("ready high while waiting");

   property p_sync_ready;
      @(posedge clk) disable iff (!resetn)
      !sync_s |=> !step_ready_out;
   endproperty
   a_sync_ready: assert property (p_sync_ready) else $error("ready high while sync low");

   property p_idle_ready;
      @(posedge clk) disable iff (!resetn)
      (sync_s && st_q == adaptive_step_pkg::ST_NORMAL) |=> step_ready_out;
   endproperty
   a_idle_ready: assert property (p_idle_ready) else $error("ready low outside adaptive");

   property p_quiet_off;
      @(posedge clk) disable iff (!resetn)
      quiet_chopper_active |=> (!adaptive_active_out && !const_off_slow_decay_out);
   endproperty
   a_quiet_off: assert property (p_quiet_off) else $error("adaptive with quiet chopper");

   property p_off_cap;
      @(posedge clk) disable iff (!resetn)
      (active_d && chopper_off_time > 4'h8) |=> (eff_off_time_out == 4'h8);
   endproperty
   a_off_cap: assert property (p_off_cap) else $error("off time not capped");

   property p_buffer_limit;
      @(posedge clk) disable iff (!resetn)
      pend_q <= 10'h100;
   endproperty
   a_buffer_limit: assert property (p_buffer_limit) else $error("buffer over one fullstep");

   property p_lost_count;
      @(posedge clk) disable iff (!resetn)
      (lost_ev && !dir_s) |=> (lost_steps_out == $past(lost_steps_out) + 20'h00001);
   endproperty
   a_lost_count: assert property (p_lost_count) else $error("lost count not raised");

   property p_skip_toggle;
      @(posedge clk) disable iff (!resetn)
      lost_ev |=> (skip_q != $past(skip_q));
   endproperty
   a_skip_toggle: assert property (p_skip_toggle) else $error("skip output not toggled");

   property p_override;
      @(posedge clk) disable iff (!resetn)
      (override_ev && active_d && st_q == adaptive_step_pkg::ST_WAIT) |=>
         (st_q == adaptive_step_pkg::ST_RUN);
   endproperty
   a_override: assert property (p_override) else $error("long step did not end wait");

   property p_stall_set;
      @(posedge clk) disable iff (!resetn)
      stall_ev |=> stall_flag_out;
   endproperty
   a_stall_set: assert property (p_stall_set) else $error("stall flag not set");

endmodule // load_adaptive_step_diag

/* File: test/step_ctrl_model.sv */
// motion controller model: step and direction pulses toward the driver
module step_ctrl_model (
   // clock and ready feedback
   input wire logic clk,
   input wire logic step_ready_out,
   // step pins
   output logic step_in,
   output logic dir_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins idle low until the first step
   initial begin
      step_in = 1'b0;
      dir_in = 1'b0;
   end

   // one step; direction set a cycle ahead and held after the pulse
   task automatic send_step(input logic d, input bit hold_off, input int hi, input int max_wait);
      int n;
      n = 0;
      @(posedge clk);
      dir_in <= d;
      while (hold_off && step_ready_out !== 1'b1 && n < max_wait) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      step_in <= 1'b1;
      repeat (hi) @(posedge clk);
      step_in <= 1'b0;
      repeat (3) @(posedge clk); // low time well past the synchroniser
   endtask
endmodule // step_ctrl_model

/* File: test/load_adaptive_step_diag_test.sv */
// self-checking bench for the load adaptive step block
module load_adaptive_step_diag_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, resetn, step_in, dir_in, adaptive_force_in, step_wait_sync_in, step_ready_out;
   logic [22:0] adaptive_min_velocity, velocity_in;
   logic quiet_chopper_active, vhigh_fullstep_en, vhigh_chopper_en, chop_on_a, chop_on_b;
   logic [3:0] chopper_off_time, eff_off_time_out;
   logic [8:0] microstep_width, load_value_out, w;
   logic [15:0] blocked_step_period;
   logic [9:0] load_meas_pulse_width, mscnt_out, ms;
   logic [7:0] adaptive_stall_sensitivity;
   logic motor_step_done, diag_first_push_pull, diag_second_push_pull;
   logic [1:0] diag_first_src, diag_second_src;
   logic diag_out_first_o, diag_out_first_oe, diag_out_second_o, diag_out_second_oe;
   logic [adaptive_step_pkg::LOST_W-1:0] lost_steps_out;
   logic stall_flag_out, adaptive_active_out, fullstep_mode_out, const_off_slow_decay_out;
   logic tog_exp;
   logic [31:0] seed = 32'h0B49;
   logic [31:0] r;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int chop_hi = 0;

   load_adaptive_step_diag uut (.clk, .resetn, .step_in, .dir_in, .adaptive_force_in,
      .step_wait_sync_in, .step_ready_out, .adaptive_min_velocity, .velocity_in,
      .quiet_chopper_active, .vhigh_fullstep_en, .vhigh_chopper_en, .chopper_off_time,
      .microstep_width, .blocked_step_period, .load_meas_pulse_width,
      .adaptive_stall_sensitivity, .motor_step_done, .chop_on_a, .chop_on_b,
      .diag_first_src, .diag_first_push_pull, .diag_second_src, .diag_second_push_pull,
      .diag_out_first_o, .diag_out_first_oe, .diag_out_second_o, .diag_out_second_oe,
      .mscnt_out, .lost_steps_out, .load_value_out, .stall_flag_out, .adaptive_active_out,
      .fullstep_mode_out, .const_off_slow_decay_out, .eff_off_time_out);

   step_ctrl_model ctrl (.clk, .step_ready_out, .step_in, .dir_in);

   // xorshift source, fixed seed keeps runs repeatable
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected counter after one step
   function logic [9:0] ms_next(logic [9:0] m, logic d, logic [8:0] s);
      return d ? m - s : m + s;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // cycle ceiling; chopper phases keep toggling so the chop-on path moves
   always @(posedge clk) begin
      cyc <= cyc + 1;
      chop_on_a <= cyc[2];
      chop_on_b <= cyc[3];
      if (cyc == 6000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      resetn = 1'b0;
      {adaptive_force_in, quiet_chopper_active, vhigh_fullstep_en, vhigh_chopper_en} = 4'h0;
      {motor_step_done, diag_first_push_pull} = 2'h0;
      step_wait_sync_in = 1'b1;
      adaptive_min_velocity = 23'h000000;
      velocity_in = 23'h000000;
      chopper_off_time = 4'h0;
      microstep_width = 9'h001;
      blocked_step_period = 16'hFFFF; // wait ends only by motor or override
      load_meas_pulse_width = 10'h01E;
      adaptive_stall_sensitivity = 8'hFF;
      diag_first_src = adaptive_step_pkg::DIAG_SRC_STALL;
      diag_second_src = adaptive_step_pkg::DIAG_SRC_INDEX; // index first, skipped later
      diag_second_push_pull = 1'b1;
      ms = adaptive_step_pkg::MSCNT_RST;
      repeat (7) @(posedge clk);
      #1;
      check(diag_out_first_oe, 1);
      check(diag_out_second_oe, 0);
      @(posedge clk) resetn <= 1'b1;
      repeat (6) @(posedge clk);
      check(step_ready_out, 1);
      check(diag_out_first_oe, 0);
      check(diag_out_second_oe, 1);
      check(diag_out_second_o, 1);
      // random widths and directions in normal mode
      for (int i = 0; i < 8; i++) begin
         r = xs();
         w = 9'h001 << (r[3:0] % 9);
         microstep_width <= w;
         ctrl.send_step(r[4], 1'b1, 3, 20);
         repeat (4) @(posedge clk);
         ms = ms_next(ms, r[4], w);
         check(mscnt_out, ms);
         check(diag_out_second_o, ms == 10'h000);
      end
      $display("test normal stepping done");
      @(posedge clk) step_wait_sync_in <= 1'b0;
      repeat (4) @(posedge clk);
      check(step_ready_out, 0);
      ctrl.send_step(1'b0, 1'b0, 3, 0);
      repeat (4) @(posedge clk);
      check(mscnt_out, ms);
      step_wait_sync_in <= 1'b1;
      repeat (6) @(posedge clk);
      ms = ms_next(ms, 1'b0, w);
      check(mscnt_out, ms);
      $display("test sync done");
      adaptive_force_in <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         chopper_off_time <= k[3:0];
         repeat (5) @(posedge clk);
         check(eff_off_time_out, (k > 8) ? 8 : k);
         check(adaptive_active_out, 1);
         check(const_off_slow_decay_out, 1);
      end
      quiet_chopper_active <= 1'b1;
      repeat (4) @(posedge clk);
      check(adaptive_active_out, 0);
      {quiet_chopper_active, adaptive_force_in} <= 2'h0;
      {vhigh_fullstep_en, vhigh_chopper_en} <= 2'h3;
      adaptive_min_velocity <= 23'h000064;
      velocity_in <= 23'h000065;
      repeat (5) @(posedge clk);
      check(adaptive_active_out, 1);
      check(fullstep_mode_out, 1);
      velocity_in <= 23'h000064;
      repeat (4) @(posedge clk);
      check(adaptive_active_out, 0);
      adaptive_min_velocity <= 23'h000000;
      velocity_in <= 23'h7FFFFF;
      repeat (4) @(posedge clk);
      check(adaptive_active_out, 0);
      $display("test mode select done");
      velocity_in <= 23'h000000;
      adaptive_force_in <= 1'b1;
      microstep_width <= 9'h100;
      diag_second_src <= adaptive_step_pkg::DIAG_SRC_SKIPPED;
      repeat (6) @(posedge clk);
      tog_exp = ~diag_out_second_o;
      ctrl.send_step(1'b0, 1'b0, 3, 0);
      repeat (4) @(posedge clk);
      ms = ms_next(ms, 1'b0, 9'h100);
      check(mscnt_out, ms);
      check(step_ready_out, 0);
      ctrl.send_step(1'b0, 1'b0, 3, 0); // buffered while waiting
      ctrl.send_step(1'b0, 1'b0, 3, 0); // beyond one fullstep, so lost
      repeat (2) @(posedge clk);
      check(lost_steps_out, 1);
      check(diag_out_second_o, tog_exp);
      repeat (20) @(posedge clk);
      check(stall_flag_out, 1);
      check(diag_out_first_oe, 1);
      check(diag_out_first_o, 0);
      @(posedge clk) motor_step_done <= 1'b1;
      @(posedge clk) motor_step_done <= 1'b0;
      repeat (4) @(posedge clk);
      check(stall_flag_out, 0);
      // wait entered six cycles after the call, motor pulse 45 cycles later
      check(load_value_out, 9'h02D);
      ms = ms_next(ms, 1'b0, 9'h100);
      check(mscnt_out, ms);
      ctrl.send_step(1'b0, 1'b0, 1100, 0);
      repeat (2) @(posedge clk);
      ms = ms_next(ms, 1'b0, 9'h100);
      check(mscnt_out, ms);
      $display("test adaptive wait done");
      // coil a on 4 of 8, b on 8 of 16: alternating shows 11 of every 16 cycles
      diag_first_src <= adaptive_step_pkg::DIAG_SRC_CHOP_ON;
      repeat (4) @(posedge clk);
      repeat (64) begin
         @(posedge clk);
         chop_hi += diag_out_first_oe;
      end
      check(chop_hi, 44);
      $display("test diag sources done");
      end_of_test();
   end
endmodule // load_adaptive_step_diag_test
